// ===== rtl/ftic_top.v
`timescale 1ns/100ps
`include "ftic_regs.vh"
// What this block does
// - overcurrent with enable turns off bridge/reverse
// - faults with the phase enable switch all three phases off
// - pos overcurrent has three routing enables
// - neg overcurrent has three routing enables
// - pos undervoltage has three routing enables
// - neg undervoltage has three routing enables
// - low external fault pin is a fault
// - fault pin has three routing enables
// - any enabled firing trigger suffices
// - fault status clears by writing one
// - reverse turn-off armable from all five triggers
// - qualify bit adds current condition for reverse
// - all actions zero means faults ignored
// - latched driver enables readable as status
module ftic_top (
  input wire clk,
  input wire resetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire positive_overcurrent_trigger,
  input wire negative_overcurrent_trigger,
  input wire positive_undervoltage_trigger,
  input wire negative_undervoltage_trigger,
  input wire external_fault_pin_n,
  input wire reverse_current_present,
  output reg bridge_gate_output,
  output reg reverse_gate_output,
  output reg [2:0] phase_gate_output,
  output reg charge_pump_enable
);

  // synchronised pin inputs
  // fault pin inverted ahead of the flops so reset reads as no fault
  wire [5:0] pins_raw;
  wire [5:0] pins_sync;
  wire [`FTIC_NUM_TRIG-1:0] trig;
  wire rev_current;

  assign pins_raw = {reverse_current_present, ~external_fault_pin_n, negative_undervoltage_trigger,
                     positive_undervoltage_trigger, negative_overcurrent_trigger,
                     positive_overcurrent_trigger};

  ftic_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins_sync)
  );

  assign trig = pins_sync[4:0];
  assign rev_current = pins_sync[5];

  // configuration
  reg [14:0] action;
  reg reverse_current_qualify;
  reg [`FTIC_NUM_TRIG-1:0] fault_latched;

  // bit j of action group: one bit per trigger
  function [`FTIC_NUM_TRIG-1:0] action_group;
    input [14:0] act;
    input integer sel;
    integer t;
    begin
      action_group = {`FTIC_NUM_TRIG{1'b0}};
      for (t = 0; t < `FTIC_NUM_TRIG; t = t + 1) begin
        action_group[t] = act[3 * t + sel];
      end
    end
  endfunction

  wire [`FTIC_NUM_TRIG-1:0] brg_route;
  wire [`FTIC_NUM_TRIG-1:0] rev_route;
  wire [`FTIC_NUM_TRIG-1:0] ph_route;
  wire brg_fault_off;
  wire rev_fault_off;
  wire phase_hold;

  assign brg_route = action_group(action, `FTIC_ACT_BRG);
  assign rev_route = action_group(action, `FTIC_ACT_REV);
  assign ph_route = action_group(action, `FTIC_ACT_PH);
  assign brg_fault_off = |(brg_route & trig);
  // with the qualify bit set, reverse waits for the current condition
  assign rev_fault_off = (|(rev_route & trig)) & (~reverse_current_qualify | rev_current);
  assign phase_hold = |(ph_route & trig);

  // mapped words; the status words answer reads only
  function reg_mapped;
    input [4:0] addr;
    input rd;
    begin
      reg_mapped = addr == `FTIC_CTRL_ADDR || addr == `FTIC_ACTION_ADDR || addr == `FTIC_FAULT_ADDR ||
                   (rd && (addr == `FTIC_STATE_ADDR || addr == `FTIC_LIVE_ADDR));
    end
  endfunction

  // axi write channel
  reg aw_held;
  reg w_held;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FTIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (reg_mapped(aw_addr, 1'b0))
          s_axi_bresp <= `FTIC_RESP_OKAY;
        else
          s_axi_bresp <= `FTIC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write decode, byte lane 0 and 1 honoured
  wire wr_ctrl;
  wire wr_action;
  wire wr_fault;
  wire [15:0] wd;

  assign wd = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
  assign wr_ctrl = do_write && aw_addr == `FTIC_CTRL_ADDR;
  assign wr_action = do_write && aw_addr == `FTIC_ACTION_ADDR;
  assign wr_fault = do_write && aw_addr == `FTIC_FAULT_ADDR;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      action <= `FTIC_ACTION_RESET;
      reverse_current_qualify <= 1'b0;
      charge_pump_enable <= 1'b0;
    end else begin
      if (wr_action) begin
        if (w_strb[0])
          action[7:0] <= w_data[7:0];
        if (w_strb[1])
          action[14:8] <= w_data[14:8];
      end
      if (wr_ctrl && w_strb[0])
        charge_pump_enable <= w_data[`FTIC_CTRL_CP_EN];
      if (wr_ctrl && w_strb[1])
        reverse_current_qualify <= w_data[`FTIC_CTRL_REV_QUAL];
    end
  end

  wire [`FTIC_NUM_TRIG-1:0] fault_clear;

  assign fault_clear = wr_fault ? wd[`FTIC_NUM_TRIG-1:0] : {`FTIC_NUM_TRIG{1'b0}};

  // sticky fault flags, set beats write-one clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_latched <= {`FTIC_NUM_TRIG{1'b0}};
    end else begin
      fault_latched <= (fault_latched & ~fault_clear) | trig;
    end
  end

  // driver latches: on needs on=1 and off=0 in one write
  wire brg_on_cmd;
  wire brg_off_cmd;
  wire rev_on_cmd;
  wire rev_off_cmd;
  wire [2:0] ph_on_cmd;
  wire [2:0] ph_off_cmd;
  wire [2:0] next_phase;

  // turn-on form: on bit set and off bit clear
  function cmd_on;
    input on_bit;
    input off_bit;
    begin
      cmd_on = on_bit & ~off_bit;
    end
  endfunction

  // off bit, or lane 0 written with the on bit clear
  function cmd_off;
    input lane0;
    input on_bit;
    input off_bit;
    begin
      cmd_off = off_bit | (lane0 & ~on_bit);
    end
  endfunction

  assign brg_on_cmd = wr_ctrl & cmd_on(wd[`FTIC_CTRL_BRG_ON], wd[`FTIC_CTRL_BRG_OFF]);
  assign brg_off_cmd = wr_ctrl & cmd_off(w_strb[0], wd[`FTIC_CTRL_BRG_ON], wd[`FTIC_CTRL_BRG_OFF]);
  assign rev_on_cmd = wr_ctrl & cmd_on(wd[`FTIC_CTRL_REV_ON], wd[`FTIC_CTRL_REV_OFF]);
  assign rev_off_cmd = wr_ctrl & cmd_off(w_strb[0], wd[`FTIC_CTRL_REV_ON], wd[`FTIC_CTRL_REV_OFF]);
  assign ph_on_cmd[0] = wr_ctrl & cmd_on(wd[`FTIC_CTRL_U_ON], wd[`FTIC_CTRL_U_OFF]);
  assign ph_on_cmd[1] = wr_ctrl & cmd_on(wd[`FTIC_CTRL_V_ON], wd[`FTIC_CTRL_V_OFF]);
  assign ph_on_cmd[2] = wr_ctrl & cmd_on(wd[`FTIC_CTRL_W_ON], wd[`FTIC_CTRL_W_OFF]);
  assign ph_off_cmd[0] = wr_ctrl & wd[`FTIC_CTRL_U_OFF];
  assign ph_off_cmd[1] = wr_ctrl & wd[`FTIC_CTRL_V_OFF];
  assign ph_off_cmd[2] = wr_ctrl & wd[`FTIC_CTRL_W_OFF];
  assign next_phase = (phase_gate_output & ~ph_off_cmd) | ph_on_cmd;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bridge_gate_output <= 1'b0;
      reverse_gate_output <= 1'b0;
      phase_gate_output <= 3'h0;
    end else begin
      // fault wins over a turn-on in the same cycle
      if (brg_fault_off || brg_off_cmd)
        bridge_gate_output <= 1'b0;
      else if (brg_on_cmd)
        bridge_gate_output <= 1'b1;
      if (rev_fault_off || rev_off_cmd)
        reverse_gate_output <= 1'b0;
      else if (rev_on_cmd)
        reverse_gate_output <= 1'b1;
      if (phase_hold)
        phase_gate_output <= 3'h0;
      else
        phase_gate_output <= next_phase;
    end
  end

  // axi read channel
  wire [31:0] ctrl_view;
  wire [31:0] state_view;
  wire [31:0] live_view;

  assign ctrl_view = {20'h00000, reverse_current_qualify, 10'h000, charge_pump_enable};
  assign state_view = {26'h0000000, charge_pump_enable, phase_gate_output,
                       reverse_gate_output, bridge_gate_output};
  assign live_view = {26'h0000000, rev_current, trig};
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FTIC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_mapped(s_axi_araddr, 1'b1) ? `FTIC_RESP_OKAY : `FTIC_RESP_SLVERR;
        case (s_axi_araddr)
          `FTIC_CTRL_ADDR: s_axi_rdata <= ctrl_view;
          `FTIC_ACTION_ADDR: s_axi_rdata <= {17'h00000, action};
          `FTIC_FAULT_ADDR: s_axi_rdata <= {27'h0000000, fault_latched};
          `FTIC_STATE_ADDR: s_axi_rdata <= state_view;
          `FTIC_LIVE_ADDR: s_axi_rdata <= live_view;
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== rtl/ftic_regs.vh
`ifndef FTIC_REGS_VH
`define FTIC_REGS_VH

// register byte offsets
`define FTIC_CTRL_ADDR 5'h00
`define FTIC_ACTION_ADDR 5'h04
`define FTIC_FAULT_ADDR 5'h08
`define FTIC_STATE_ADDR 5'h0C
`define FTIC_LIVE_ADDR 5'h10

// control register fields
`define FTIC_CTRL_CP_EN 0
`define FTIC_CTRL_BRG_ON 1
`define FTIC_CTRL_BRG_OFF 2
`define FTIC_CTRL_REV_ON 3
`define FTIC_CTRL_REV_OFF 4
`define FTIC_CTRL_U_ON 5
`define FTIC_CTRL_U_OFF 6
`define FTIC_CTRL_V_ON 7
`define FTIC_CTRL_V_OFF 8
`define FTIC_CTRL_W_ON 9
`define FTIC_CTRL_W_OFF 10
`define FTIC_CTRL_REV_QUAL 11

// action register: bit 3*trigger + {0 bridge, 1 reverse, 2 phase latch}
// trigger order: 0 pos oc, 1 neg oc, 2 pos uv, 3 neg uv, 4 fault pin
`define FTIC_NUM_TRIG 5
`define FTIC_ACT_BRG 0
`define FTIC_ACT_REV 1
`define FTIC_ACT_PH 2
`define FTIC_ACTION_RESET 15'h0000

// driver state register fields
`define FTIC_ST_BRG 0
`define FTIC_ST_REV 1
`define FTIC_ST_U 2
`define FTIC_ST_V 3
`define FTIC_ST_W 4
`define FTIC_ST_CP 5

// axi responses
`define FTIC_RESP_OKAY 2'h0
`define FTIC_RESP_SLVERR 2'h2

`endif

// ===== rtl/ftic_sync.v
`timescale 1ns/100ps
module ftic_sync #(
  parameter WIDTH = 6
) (
  clk,
  resetn,
  d,
  q
);
  input clk;
  input resetn;
  input [WIDTH-1:0] d;
  output [WIDTH-1:0] q;
  wire clk;
  wire resetn;
  wire [WIDTH-1:0] d;
  reg [WIDTH-1:0] q;
  reg [WIDTH-1:0] stage1;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

// ===== testbench/ftic_assertions.sv
`timescale 1ns/100ps
module ftic_assertions (
  input wire clk,
  input wire resetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire positive_overcurrent_trigger,
  input wire negative_overcurrent_trigger,
  input wire positive_undervoltage_trigger,
  input wire negative_undervoltage_trigger,
  input wire external_fault_pin_n,
  input wire bridge_gate_output,
  input wire reverse_gate_output,
  input wire [2:0] phase_gate_output
);
  reg [3:0] hist;
  wire flt = positive_overcurrent_trigger | negative_overcurrent_trigger | positive_undervoltage_trigger |
    negative_undervoltage_trigger | ~external_fault_pin_n;
  // recent fault activity, covers the sync delay
  always @(posedge clk or negedge resetn) begin
    if (!resetn) hist <= 4'h0;
    else hist <= {hist[2:0], flt};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_BRG_RISE: assert property ($rose(bridge_gate_output) |-> $rose(s_axi_bvalid))
    else $error("bridge on without write");
  AST_REV_RISE: assert property ($rose(reverse_gate_output) |-> $rose(s_axi_bvalid))
    else $error("reverse on without write");
  AST_PH_RISE: assert property (|(phase_gate_output & ~$past(phase_gate_output)) |->
    $rose(s_axi_bvalid) || |hist) else $error("phase on without cause");
  AST_BRG_FALL: assert property ($fell(bridge_gate_output) |-> $rose(s_axi_bvalid) || |hist)
    else $error("bridge off without cause");
  AST_REV_FALL: assert property ($fell(reverse_gate_output) |-> $rose(s_axi_bvalid) || |hist)
    else $error("reverse off without cause");
  AST_PH_FALL: assert property (|(~phase_gate_output & $past(phase_gate_output)) |->
    $rose(s_axi_bvalid) || |hist) else $error("phase off without cause");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule

// ===== testbench/ftic_host.sv
`timescale 1ns/100ps
module ftic_host (
  input wire clk,
  output reg [4:0] awaddr,
  output reg awvalid,
  input wire awready,
  output reg [31:0] wdata,
  output wire [3:0] wstrb,
  output reg wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  output reg bready,
  output reg [4:0] araddr,
  output reg arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  output reg rready
);
  assign wstrb = 4'hF;
  initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = 0;
  task wr(input [4:0] a, input [31:0] dv, output [1:0] rs);
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge clk);
      while (!bvalid) begin
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        @(posedge clk);
      end
      rs = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, output [31:0] dv, output [1:0] rs);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge clk);
      while (!rvalid) begin
        if (arready) arvalid <= 1'b0;
        @(posedge clk);
      end
      dv = rdata;
      rs = rresp;
      rready <= 1'b0;
    end
  endtask
endmodule

// ===== testbench/ftic_bench.sv
`timescale 1ns/100ps
`include "ftic_regs.vh"
module ftic_bench;
  localparam [4:0] CT = `FTIC_CTRL_ADDR;
  localparam [4:0] AC = `FTIC_ACTION_ADDR;
  localparam [4:0] FA = `FTIC_FAULT_ADDR;
  localparam [4:0] ST = `FTIC_STATE_ADDR;
  localparam [4:0] LV = `FTIC_LIVE_ADDR;
  reg clk = 0;
  reg resetn = 0;
  reg [4:0] flt = 0;
  reg cur = 0;
  wire [4:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready;
  wire arvalid, arready, rvalid, rready, brg, rev, cp;
  wire [2:0] ph;
  integer mismatches = 0;
  integer check_count = 0;
  integer t, k;
  reg [31:0] d;
  reg [1:0] r;
  initial forever #12.5 clk = ~clk;
  ftic_host HOST (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  ftic_top DUT (.clk, .resetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .positive_overcurrent_trigger(flt[0]),
    .negative_overcurrent_trigger(flt[1]), .positive_undervoltage_trigger(flt[2]),
    .negative_undervoltage_trigger(flt[3]), .external_fault_pin_n(~flt[4]),
    .reverse_current_present(cur), .bridge_gate_output(brg), .reverse_gate_output(rev),
    .phase_gate_output(ph), .charge_pump_enable(cp));
  task chk(input [47:0] n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task gchk(input [5:0] e);
    begin
      #1;
      chk("gates", e, {cp, ph, rev, brg});
    end
  endtask
  task rdc(input [4:0] a, input [31:0] e);
    begin
      HOST.rd(a, d, r);
      chk("rdata", e, d);
      chk("rresp", `FTIC_RESP_OKAY, r);
    end
  endtask
  task setf(input [4:0] f, input c);
    begin
      @(posedge clk);
      flt <= f;
      cur <= c;
      repeat (4) @(posedge clk);
    end
  endtask
  task t_regs;
    begin
      rdc(ST, 32'h0);
      rdc(AC, 32'h0);
      HOST.rd(5'h14, d, r);
      chk("rresp", `FTIC_RESP_SLVERR, r);
      chk("rdata", 32'h0, d);
      HOST.wr(ST, 32'h1F, r);
      chk("bresp", `FTIC_RESP_SLVERR, r);
      rdc(ST, 32'h0);
      $display("done regs");
    end
  endtask
  task t_manual;
    begin
      HOST.wr(CT, 32'h2AB, r);
      chk("bresp", `FTIC_RESP_OKAY, r);
      gchk(6'h3F);
      setf(5'h1F, 1'b1);
      gchk(6'h3F);
      rdc(FA, 32'h1F);
      setf(5'h00, 1'b0);
      HOST.wr(FA, 32'h1F, r);
      rdc(FA, 32'h0);
      HOST.wr(CT, 32'h40, r);
      gchk(6'h18);
      $display("done manual");
    end
  endtask
  task t_qual;
    begin
      HOST.wr(AC, 32'h2, r);
      HOST.wr(CT, 32'hAAB, r);
      setf(5'h01, 1'b0);
      gchk(6'h3F);
      setf(5'h01, 1'b1);
      gchk(6'h3D);
      setf(5'h00, 1'b0);
      HOST.wr(FA, 32'h1F, r);
      $display("done qual");
    end
  endtask
  task t_route;
    begin
      for (t = 0; t < 5; t = t + 1) begin
        for (k = 0; k < 3; k = k + 1) begin
          HOST.wr(CT, 32'h1, r);
          HOST.wr(AC, 32'h1 << (3 * t + k), r);
          HOST.wr(CT, 32'h2AB, r);
          setf(5'h01 << t, 1'b0);
          gchk({1'b1, (k == 2) ? 3'h0 : 3'h7, k != 1, k != 0});
          HOST.wr(CT, 32'h2AB, r);
          gchk({1'b1, (k == 2) ? 3'h0 : 3'h7, k != 1, k != 0});
          rdc(FA, 32'h1 << t);
          setf(5'h00, 1'b0);
          HOST.wr(FA, 32'h1 << t, r);
          rdc(FA, 32'h0);
          HOST.wr(CT, 32'h2AB, r);
          gchk(6'h3F);
          rdc(ST, 32'h3F);
        end
      end
      $display("done route");
    end
  endtask
  task t_reset;
    begin
      HOST.wr(AC, 32'h208, r);
      HOST.wr(CT, 32'hAAB, r);
      rdc(CT, 32'h801);
      setf(5'h11, 1'b1);
      gchk(6'h3F);
      rdc(LV, 32'h31);
      setf(5'h08, 1'b0);
      gchk(6'h3E);
      setf(5'h02, 1'b0);
      gchk(6'h3E);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      gchk(6'h00);
      rdc(AC, 32'h0);
      rdc(CT, 32'h0);
      rdc(FA, 32'h2);
      rdc(ST, 32'h0);
      HOST.wr(FA, 32'h2, r);
      rdc(FA, 32'h2);
      setf(5'h00, 1'b0);
      HOST.wr(FA, 32'h2, r);
      rdc(FA, 32'h0);
      $display("done reset");
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_manual;
    t_qual;
    t_route;
    t_reset;
    test_done;
  end
  initial begin
    #500000;
    mismatches = mismatches + 1;
    test_done;
  end
endmodule
bind ftic_top ftic_assertions CHK (.clk, .resetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .positive_overcurrent_trigger, .negative_overcurrent_trigger,
  .positive_undervoltage_trigger, .negative_undervoltage_trigger, .external_fault_pin_n,
  .bridge_gate_output, .reverse_gate_output, .phase_gate_output);
